/* bench/cpsr_core_properties.sv */
// Port checks of the counter and status block
`timescale 1ns/1ps
module cpsr_core_props
   import cpsr_pkg::*;
#(
   parameter bit SIM_VARIANT = 1'b0
)
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [5:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic instr_valid_in,
   input wire cpsr_op_t instr_op_in,
   input wire logic [10:0] instr_operand_in,
   input wire logic [7:0] acc_in,
   input wire logic instr_ready_out,
   input wire cpsr_pc_t pc_out,
   input wire logic wake_reset_in,
   input wire logic wdt_timeout_in,
   input wire logic [5:0] data_addr_in,
   input wire logic [6:0] data_phys_addr_out,
   input wire logic data_special_out,
   input wire logic indirect_we_out,
   input wire logic control_segment_select_out,
   input wire logic [7:0] port_seven_out,
   input wire logic osc_freq_sel_hi_out,
   input wire logic osc_freq_sel_lo_out,
   input wire logic [3:0] osc_trim_field_out
);
   // ==========================================================
   // Shared terms
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rstn_in);
   wire take = instr_valid_in && instr_ready_out;
   wire rd_ans = avs_read_in && !avs_waitrequest_out;
   wire long_op = instr_op_in inside {OP_LONG_JUMP, OP_LONG_SUBROUTINE_CALL};
   // Program counter loading
   // long jump target
   a_long_jump_load: assert property (
      take && instr_op_in == OP_LONG_JUMP |=> pc_out == $past(instr_operand_in))
      else $error("long jump");
   a_page_keep_top: assert property (
      take && instr_op_in inside {OP_PAGE_JUMP, OP_PAGE_CALL}
      |=> pc_out == {$past(pc_out[10]), $past(instr_operand_in[9:0])})
      else $error("page bit lost");
   a_move_keep_high: assert property (
      take && instr_op_in == OP_MOVE_ACC_TO_PC
      |=> pc_out == {$past(pc_out[10:8]), $past(acc_in)})
      else $error("move changed top");
   a_add_full_width: assert property (
      take && instr_op_in == OP_ADD_ACC_TO_PC
      |=> pc_out == $past(pc_out) + 11'h001 + {3'h0, $past(acc_in)})
      else $error("add wrong");
   a_long_two_cycles: assert property (
      take && long_op |=> !instr_ready_out [*3])
      else $error("long op too short");
   a_short_one_cycle: assert property (
      take && !long_op |=> !instr_ready_out ##1
      (instr_ready_out || avs_write_in || wake_reset_in || wdt_timeout_in))
      else $error("short op timing");
   a_event_pc_zero: assert property (
      wake_reset_in || wdt_timeout_in |=> pc_out == 11'h000)
      else $error("counter not cleared");
   // Registers and mapping
   // segment bit readback
   a_seg_follows_bit: assert property (
      rd_ans && avs_address_in[5:2] == 4'h3
      |-> avs_readdata_out[6] == control_segment_select_out)
      else $error("segment differs");
   a_port_seven_view: assert property (
      port_seven_out[7:2] == (SIM_VARIANT ? {osc_trim_field_out, osc_freq_sel_hi_out,
      osc_freq_sel_lo_out} : 6'h00)) else $error("port seven bits");
   a_map_direct_addr: assert property (
      data_addr_in != 6'h00 |-> data_special_out == (data_addr_in < 6'h10)
      && data_phys_addr_out[5:0] == data_addr_in) else $error("direct map wrong");
   a_indirect_write: assert property (
      avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
      && avs_address_in[5:2] == 4'h0 |=> indirect_we_out)
      else $error("indirect write lost");
   // Main scenarios seen
   c_long_call: cover property (take && instr_op_in == OP_LONG_SUBROUTINE_CALL);
   c_wake_event: cover property (wake_reset_in);
   c_indirect_write: cover property (indirect_we_out);
endmodule

bind cpsr_core cpsr_core_props #(.SIM_VARIANT(SIM_VARIANT)) u_props (.*);

/* bench/cpsr_core_tb_top.sv */
// Self-checking bench of the counter and status block
`timescale 1ns/1ps
module cpsr_core_tb_top
   import cpsr_pkg::*;
;
   // ==========================================================
   // Signals and bench model
   logic clock_in = 1'h0, rstn_in = 1'h0;
   logic [5:0] avs_address_in = 6'h00, data_addr_in = 6'h00;
   logic avs_read_in = 1'h0, avs_write_in = 1'h0, instr_valid_in = 1'h0;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
   logic [3:0] avs_byteenable_in = 4'hF, osc_trim_field_out;
   cpsr_op_t instr_op_in = OP_STEP;
   logic [10:0] instr_operand_in = 11'h000, r;
   logic [7:0] acc_in = 8'h00, alu_result_in = 8'h00, indirect_rdata_in = 8'h00;
   logic flags_we_in = 1'h0, half_carry_flag_in = 1'h0, carry_flag_in = 1'h0;
   logic wake_reset_in = 1'h0, wdt_timeout_in = 1'h0, took_q = 1'h0;
   logic avs_waitrequest_out, instr_ready_out, data_special_out, indirect_we_out;
   logic control_segment_select_out, osc_freq_sel_hi_out, osc_freq_sel_lo_out;
   logic [6:0] data_phys_addr_out;
   logic [7:0] indirect_wdata_out, port_five_out, port_six_out, port_seven_out;
   cpsr_pc_t pc_out, pc_m = 11'h000;
   cpsr_pc_t pc_q [$];
   cpsr_pc_t stk [8];
   cpsr_sp_t sp_m = 3'h0;
   typedef struct {logic [31:0] e; logic [31:0] m;} cpsr_note_t;
   cpsr_note_t rd_q [$];
   cpsr_note_t n;
   logic [3:0] rst_idx [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9};
   logic [7:0] rst_val [6] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'hFC, 8'h00};
   int err_total = 0, check_count = 0, cyc = 0, seed_v;

   cpsr_core #(.SIM_VARIANT(1'b1)) dut (.*);

   // Clock and hang limit
   always #50 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end

   // Comparison and closing
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Monitor pops notes where results stand
   always @(negedge clock_in) begin
      if (avs_read_in && avs_waitrequest_out === 1'h0) begin
         n = rd_q.pop_front();
         check("readdata", avs_readdata_out & n.m, n.e);
      end
      if (took_q) check("pc", pc_out, pc_q.pop_front());
      took_q <= instr_valid_in && instr_ready_out;
   end

   // Bus and instruction drivers
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                      input logic [7:0] m);
      @(posedge clock_in);
      avs_address_in <= {idx, 2'h0};
      avs_writedata_in <= {24'h0, d};
      {avs_write_in, avs_read_in} <= {wr, !wr};
      if (!wr) rd_q.push_back('{{24'h0, d & m}, {24'hFFFFFF, m}});
      do @(negedge clock_in); while (avs_waitrequest_out !== 1'h0);
      @(posedge clock_in);
      {avs_read_in, avs_write_in} <= 2'h0;
   endtask
   task automatic instr(input cpsr_op_t op, input logic [10:0] v);
      cpsr_pc_t nx;
      nx = pc_m + 11'h001;
      case (op)
         OP_PAGE_JUMP, OP_PAGE_CALL: nx = {pc_m[10], v[9:0]};
         OP_LONG_JUMP, OP_LONG_SUBROUTINE_CALL: nx = v;
         OP_SUBROUTINE_RETURN, OP_RETURN_WITH_LITERAL, OP_INTERRUPT_RETURN: begin
            sp_m = sp_m - 3'h1;
            nx = stk[sp_m];
         end
         OP_ADD_ACC_TO_PC: nx = pc_m + 11'h001 + {3'h0, v[7:0]};
         OP_MOVE_ACC_TO_PC, OP_WRITE_PC_LOW: nx = {pc_m[10:8], v[7:0]};
         default: ;
      endcase
      if (op inside {OP_PAGE_CALL, OP_LONG_SUBROUTINE_CALL}) begin
         stk[sp_m] = pc_m + 11'h001;
         sp_m = sp_m + 3'h1;
      end
      @(posedge clock_in);
      instr_valid_in <= 1'h1;
      instr_op_in <= op;
      instr_operand_in <= v;
      acc_in <= v[7:0];
      do @(negedge clock_in); while (instr_ready_out !== 1'h1);
      @(posedge clock_in);
      instr_valid_in <= 1'h0;
      pc_q.push_back(nx);
      pc_m = nx;
   endtask
   task automatic event_pulse(input logic wake);
      @(posedge clock_in);
      {wake_reset_in, wdt_timeout_in} <= {wake, !wake};
      @(posedge clock_in);
      {wake_reset_in, wdt_timeout_in} <= 2'h0;
      {pc_m, sp_m} = 14'h0;
      @(negedge clock_in);
      check("pc", pc_out, 11'h000);
   endtask

   // Main sequence
   initial begin
      seed_v = $urandom(32'h8828);
      repeat (16) @(posedge clock_in);
      rstn_in <= 1'h1;
      check("pc", pc_out, 11'h000);
      foreach (rst_idx[i]) bus(1'h0, rst_idx[i], rst_val[i], 8'hFF);
      bus(1'h1, 4'h3, 8'hFF, 8'hFF);
      bus(1'h0, 4'h3, 8'h5F, 8'hFF);
      check("segment", control_segment_select_out, 1'h1);
      bus(1'h1, 4'h3, 8'h00, 8'hFF);
      bus(1'h0, 4'h3, 8'h18, 8'hFF);
      bus(1'h1, 4'h4, 8'hFF, 8'hFF);
      avs_byteenable_in <= 4'h0;
      bus(1'h1, 4'h4, 8'h00, 8'hFF);
      avs_byteenable_in <= 4'hF;
      bus(1'h0, 4'h4, 8'h7F, 8'hFF);
      bus(1'h1, 4'h9, 8'hFF, 8'hFF);
      bus(1'h0, 4'h9, 8'h00, 8'hFF);
      for (int i = 5; i < 7; i++) begin
         r = 11'($urandom);
         bus(1'h1, 4'(i), r[7:0], 8'hFF);
         bus(1'h0, 4'(i), r[7:0], 8'hFF);
      end
      for (int i = 0; i < 4; i++) begin
         r = 11'($urandom);
         bus(1'h1, 4'h7, {r[7:4], 2'(i), r[1:0]}, 8'hFF);
         bus(1'h0, 4'h7, {r[7:4], 2'(i), r[1:0]}, 8'hFF);
         check("osc", {osc_trim_field_out, osc_freq_sel_hi_out, osc_freq_sel_lo_out},
               {r[7:4], 2'(i)});
      end
      for (int i = 0; i < 2; i++) begin
         @(posedge clock_in);
         flags_we_in <= 1'h1;
         alu_result_in <= (i == 1) ? 8'h5A : 8'h00;
         half_carry_flag_in <= (i == 0);
         carry_flag_in <= (i == 1);
         @(posedge clock_in);
         flags_we_in <= 1'h0;
         bus(1'h0, 4'h3, (i == 1) ? 8'h01 : 8'h06, 8'h07);
      end
      instr(OP_ENTER_SLEEP_INSTR, 11'h000);
      bus(1'h0, 4'h3, 8'h10, 8'h98);
      event_pulse(1'h0);
      bus(1'h0, 4'h3, 8'h00, 8'h98);
      instr(OP_WATCHDOG_CLEAR_INSTR, 11'h000);
      bus(1'h0, 4'h3, 8'h18, 8'h98);
      event_pulse(1'h1);
      bus(1'h0, 4'h3, 8'h98, 8'h98);
      r = 11'($urandom);
      instr(OP_LONG_JUMP, {1'h1, r[9:0]});
      instr(OP_PAGE_JUMP, {1'h0, ~r[9:0]});
      instr(OP_PAGE_CALL, r);
      instr(OP_LONG_SUBROUTINE_CALL, {1'h0, r[9:0]});
      instr(OP_MOVE_ACC_TO_PC, 11'h0FE);
      instr(OP_ADD_ACC_TO_PC, 11'h0FF);
      instr(OP_WRITE_PC_LOW, r);
      instr(OP_STEP, 11'h000);
      instr(OP_RETURN_WITH_LITERAL, 11'h000);
      instr(OP_INTERRUPT_RETURN, 11'h000);
      bus(1'h1, 4'h2, r[8:1], 8'hFF);
      pc_m = {pc_m[10:8], r[8:1]};
      @(negedge clock_in);
      check("pc", pc_out, pc_m);
      bus(1'h0, 4'h2, r[8:1], 8'hFF);
      for (int i = 0; i < 9; i++) instr(OP_PAGE_CALL, 11'($urandom));
      for (int i = 0; i < 9; i++) instr(OP_SUBROUTINE_RETURN, 11'h000);
      bus(1'h1, 4'h4, 8'h65, 8'hFF);
      for (int i = 0; i < 16; i++) begin
         r = (i == 0) ? 11'h000 : 11'($urandom);
         @(posedge clock_in);
         data_addr_in <= r[5:0];
         @(negedge clock_in);
         check("phys", data_phys_addr_out,
               (r[5:0] == 6'h00) ? 7'h65 : {r[5], r[5:0]});
         check("special", data_special_out, r[5:0] != 6'h00 && r[5:0] < 6'h10);
      end
      r = 11'($urandom);
      bus(1'h1, 4'h0, r[7:0], 8'hFF);
      @(negedge clock_in);
      check("ind_we", {indirect_we_out, indirect_wdata_out}, {1'h1, r[7:0]});
      indirect_rdata_in <= ~r[7:0];
      bus(1'h0, 4'h0, ~r[7:0], 8'hFF);
      finish_test();
   end
endmodule

/* src/cpsr_consts.svh */
// Constants for the core program counter, stack and status register block
`ifndef CPSR_CONSTS_SVH
`define CPSR_CONSTS_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define CPSR_IDX_INDIRECT 4'h0
`define CPSR_IDX_PC_LOW 4'h2
`define CPSR_IDX_STATUS 4'h3
`define CPSR_IDX_RAM_SEL 4'h4
`define CPSR_IDX_PORT5 4'h5
`define CPSR_IDX_PORT6 4'h6
`define CPSR_IDX_PORT7 4'h7
`define CPSR_IDX_CORE_VIEW 4'h8
`define CPSR_IDX_LAST 4'h8

// ==========================================================
// Status register fields
`define CPSR_ST_RST 7
`define CPSR_ST_SEG 6
`define CPSR_ST_TOUT 4
`define CPSR_ST_PDOWN 3
`define CPSR_ST_ZERO 2
`define CPSR_ST_HCARRY 1
`define CPSR_ST_CARRY 0
`define CPSR_STATUS_RST 8'h18
`define CPSR_STATUS_SW_MASK 8'h47

// ==========================================================
// RAM select register fields
`define CPSR_RSEL_BANK 6
`define CPSR_RSEL_MASK 8'h7F

// ==========================================================
// Port seven fields and reset values
`define CPSR_P7_IO_MASK 8'h03
`define CPSR_P7_FREQ_LO 2
`define CPSR_P7_TRIM_LO 4
`define CPSR_P7_FREQ_RST 2'h3
`define CPSR_P7_TRIM_RST 4'hF
`define CPSR_PORT_RST 8'h00

// ==========================================================
// Program counter, paging, stack and data map
`define CPSR_PC_RST 11'h000
`define CPSR_PAGE_BITS 10
`define CPSR_SP_RST 3'h0
`define CPSR_COMMON_BASE 6'h10
`define CPSR_BANKED_BASE 6'h20

// ==========================================================
// Timing counts in oscillator clocks and instruction cycles
`define CPSR_CLK_PER_ICYCLE 3'h2
`define CPSR_LONG_ICYCLES 3'h2

`endif

/* src/cpsr_core.sv */
// Program counter, return stack, status, RAM select and port registers
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "cpsr_consts.svh"

// Summary of operation
// - Counter and stack entries are eleven bits
// - Pages are 1024 words; page jump and call stay
// - Any reset clears the whole program counter
// - Page jump loads low ten bits only
// - Page call loads ten bits, pushes next
// - Long jump loads all eleven counter bits
// - Long call loads eleven bits, pushes next
// - Returns reload counter from stack top, pop
// - Accumulator add to counter is full width
// - Accumulator move replaces low eight bits
// - Other counter writes keep bits ten..eight
// - One cycle of two clocks; long two
// - Special, common and banked data address map
// - Bit seven marks wake-up reset type
// - Bit six selects control register segment
// - Time-out bit set sleep/clear/power-on, cleared timeout
// - Power-down bit set power-on/clear, cleared sleep
// - Bits two..zero hold zero, half, carry
// - RAM select: bit7 zero, bank, address
// - Production port seven bits 7..2 read zero
// - Simulator bits 3..2 choose oscillator frequency
// - Simulator bits 7..4 trim the oscillator
// - Address zero operand reaches selected register
// - Return stack holds eight entries
module cpsr_core
   import cpsr_pkg::*;
#(
   parameter bit SIM_VARIANT = 1'b0
)
(
   input wire logic clock_in,
   input wire logic rstn_in,
   // Avalon-MM slave
   input wire logic [5:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Instruction side from the decoder
   input wire logic instr_valid_in,
   input wire cpsr_op_t instr_op_in,
   input wire logic [10:0] instr_operand_in,
   input wire logic [7:0] acc_in,
   output logic instr_ready_out,
   output cpsr_pc_t pc_out,
   // ALU flag update
   input wire logic flags_we_in,
   input wire logic [7:0] alu_result_in,
   input wire logic half_carry_flag_in,
   input wire logic carry_flag_in,
   // Reset type events
   input wire logic wake_reset_in,
   input wire logic wdt_timeout_in,
   // Data address mapping
   input wire logic [5:0] data_addr_in,
   output logic [6:0] data_phys_addr_out,
   output logic data_special_out,
   // Indirect port reached from the bus
   input wire logic [7:0] indirect_rdata_in,
   output logic indirect_we_out,
   output logic [7:0] indirect_wdata_out,
   // Configuration outputs
   output logic control_segment_select_out,
   output logic [7:0] port_five_out,
   output logic [7:0] port_six_out,
   output logic [7:0] port_seven_out,
   output logic osc_freq_sel_hi_out,
   output logic osc_freq_sel_lo_out,
   output logic [3:0] osc_trim_field_out
);

   // ==========================================================
   // Functions
   function automatic cpsr_pc_t pc_inc(input cpsr_pc_t pc);
      pc_inc = cpsr_pc_t'(pc + 11'h001);
   endfunction

   // Address and bank to location
   function automatic logic [6:0] map_addr(input logic [5:0] addr, input logic bank);
      if (addr >= `CPSR_BANKED_BASE) begin
         map_addr = {bank, addr};
      end else begin
         map_addr = {1'b0, addr};
      end
   endfunction

   function automatic logic is_long(input cpsr_op_t op);
      is_long = (op == OP_LONG_JUMP) || (op == OP_LONG_SUBROUTINE_CALL);
   endfunction

   // ==========================================================
   // Declarations
   cpsr_pc_t pc_q;
   cpsr_sp_t sp_q;
   cpsr_sp_t sp_d;
   cpsr_pc_t stack_top;
   logic push;
   logic pop;
   logic [2:0] icyc_q;
   logic take;
   logic core_reset;
   logic [7:0] status_q;
   logic [7:0] ram_sel_q;
   logic [7:0] port5_q;
   logic [7:0] port6_q;
   logic [7:0] port7_q;
   logic [7:0] port7_view;
   cpsr_bus_state_t bus_q;
   logic bus_req;
   logic bus_commit;
   logic bus_wr;
   logic [3:0] bus_idx;
   logic bus_mapped;
   logic [7:0] rd_mux;
   logic [31:0] rdata_q;
   logic indirect_we_q;
   logic [7:0] indirect_wdata_q;
   logic pc_bus_wr;

   // ==========================================================
   // Bus decode
   assign bus_req = avs_read_in || avs_write_in;
   assign bus_idx = avs_address_in[5:2];
   assign bus_mapped = (bus_idx <= `CPSR_IDX_LAST);
   assign bus_commit = bus_req && (bus_q == BUS_DONE);
   assign bus_wr = bus_commit && avs_write_in && avs_byteenable_in[0] && bus_mapped;
   assign avs_waitrequest_out = bus_req && (bus_q != BUS_DONE);
   assign pc_bus_wr = bus_wr && (bus_idx == `CPSR_IDX_PC_LOW);

   // Bus state: one wait cycle per request
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         bus_q <= BUS_IDLE;
      end else begin
         case (bus_q)
            BUS_IDLE: begin
               if (bus_req) begin
                  bus_q <= BUS_DONE;
               end
            end
            BUS_DONE: begin
               bus_q <= BUS_IDLE;
            end
            default: begin
               bus_q <= BUS_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Instruction timing
   assign core_reset = wake_reset_in || wdt_timeout_in;
   assign instr_ready_out = (icyc_q == 3'h0) && !pc_bus_wr && !core_reset;
   assign take = instr_valid_in && instr_ready_out;

   always_ff @(posedge clock_in) begin
      if (!rstn_in || core_reset) begin
         icyc_q <= 3'h0;
      end else if (take) begin
         if (is_long(instr_op_in)) begin
            icyc_q <= 3'(`CPSR_CLK_PER_ICYCLE * `CPSR_LONG_ICYCLES - 3'h1);
         end else begin
            icyc_q <= 3'(`CPSR_CLK_PER_ICYCLE - 3'h1);
         end
      end else if (icyc_q != 3'h0) begin
         icyc_q <= icyc_q - 3'h1;
      end
   end

   // ==========================================================
   // Return stack
   // push on calls
   assign push = take && ((instr_op_in == OP_PAGE_CALL) ||
                          (instr_op_in == OP_LONG_SUBROUTINE_CALL));
   assign pop = take && ((instr_op_in == OP_SUBROUTINE_RETURN) ||
                         (instr_op_in == OP_RETURN_WITH_LITERAL) ||
                         (instr_op_in == OP_INTERRUPT_RETURN));

   always_comb begin
      sp_d = sp_q;
      if (core_reset) begin
         sp_d = `CPSR_SP_RST;
      end else if (push) begin
         sp_d = sp_q + 3'h1;
      end else if (pop) begin
         sp_d = sp_q - 3'h1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         sp_q <= `CPSR_SP_RST;
      end else begin
         sp_q <= sp_d;
      end
   end

   cpsr_stack_mem u_stack (
      .clock_in (clock_in),
      .rstn_in (rstn_in),
      .we_in (push),
      .waddr_in (sp_q),
      .wdata_in (pc_inc(pc_q)),
      .raddr_in (sp_d - 3'h1),
      .rdata_out (stack_top)
   );

   // ==========================================================
   // Program counter
   // eleven bit counter
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         pc_q <= `CPSR_PC_RST;
      end else if (core_reset) begin
         pc_q <= `CPSR_PC_RST;
      end else if (pc_bus_wr) begin
         pc_q <= {pc_q[10:8], avs_writedata_in[7:0]};
      end else if (take) begin
         case (instr_op_in)
            OP_PAGE_JUMP, OP_PAGE_CALL: begin
               pc_q <= {pc_q[10:`CPSR_PAGE_BITS], instr_operand_in[`CPSR_PAGE_BITS-1:0]};
            end
            OP_LONG_JUMP, OP_LONG_SUBROUTINE_CALL: begin
               pc_q <= instr_operand_in;
            end
            OP_SUBROUTINE_RETURN, OP_RETURN_WITH_LITERAL, OP_INTERRUPT_RETURN: begin
               pc_q <= stack_top;
            end
            OP_ADD_ACC_TO_PC: begin
               pc_q <= cpsr_pc_t'(pc_inc(pc_q) + {3'h0, acc_in});
            end
            OP_MOVE_ACC_TO_PC: begin
               pc_q <= {pc_q[10:8], acc_in};
            end
            OP_WRITE_PC_LOW: begin
               pc_q <= {pc_q[10:8], instr_operand_in[7:0]};
            end
            default: begin
               pc_q <= pc_inc(pc_q);
            end
         endcase
      end
   end

   assign pc_out = pc_q;

   // ==========================================================
   // Status; events win over bus writes
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         status_q <= `CPSR_STATUS_RST;
      end else begin
         if (bus_wr && (bus_idx == `CPSR_IDX_STATUS)) begin
            status_q[`CPSR_ST_SEG] <= avs_writedata_in[`CPSR_ST_SEG];
            status_q[`CPSR_ST_ZERO] <= avs_writedata_in[`CPSR_ST_ZERO];
            status_q[`CPSR_ST_HCARRY] <= avs_writedata_in[`CPSR_ST_HCARRY];
            status_q[`CPSR_ST_CARRY] <= avs_writedata_in[`CPSR_ST_CARRY];
         end
         if (flags_we_in) begin
            status_q[`CPSR_ST_ZERO] <= (alu_result_in == 8'h00);
            status_q[`CPSR_ST_HCARRY] <= half_carry_flag_in;
            status_q[`CPSR_ST_CARRY] <= carry_flag_in;
         end
         // time-out set by sleep and clear
         // power-down set by clear, cleared by sleep
         if (take && (instr_op_in == OP_ENTER_SLEEP_INSTR)) begin
            status_q[`CPSR_ST_TOUT] <= 1'b1;
            status_q[`CPSR_ST_PDOWN] <= 1'b0;
         end
         if (take && (instr_op_in == OP_WATCHDOG_CLEAR_INSTR)) begin
            status_q[`CPSR_ST_TOUT] <= 1'b1;
            status_q[`CPSR_ST_PDOWN] <= 1'b1;
         end
         if (wake_reset_in) begin
            status_q[`CPSR_ST_RST] <= 1'b1;
         end
         if (wdt_timeout_in) begin
            status_q[`CPSR_ST_RST] <= 1'b0;
            status_q[`CPSR_ST_TOUT] <= 1'b0;
         end
         status_q[5] <= 1'b0;
      end
   end

   assign control_segment_select_out = status_q[`CPSR_ST_SEG];

   // ==========================================================
   // RAM select and address mapping
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         ram_sel_q <= 8'h00;
      end else if (bus_wr && (bus_idx == `CPSR_IDX_RAM_SEL)) begin
         ram_sel_q <= avs_writedata_in[7:0] & `CPSR_RSEL_MASK;
      end
   end

   // address zero redirected through RAM select
   always_comb begin
      if (data_addr_in == 6'h00) begin
         data_phys_addr_out = map_addr(ram_sel_q[5:0], ram_sel_q[`CPSR_RSEL_BANK]);
         data_special_out = (ram_sel_q[5:0] < `CPSR_COMMON_BASE);
      end else begin
         data_phys_addr_out = map_addr(data_addr_in, ram_sel_q[`CPSR_RSEL_BANK]);
         data_special_out = (data_addr_in < `CPSR_COMMON_BASE);
      end
   end

   // bus writes to the indirect port
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         indirect_we_q <= 1'b0;
         indirect_wdata_q <= 8'h00;
      end else begin
         indirect_we_q <= bus_wr && (bus_idx == `CPSR_IDX_INDIRECT);
         if (bus_wr && (bus_idx == `CPSR_IDX_INDIRECT)) begin
            indirect_wdata_q <= avs_writedata_in[7:0];
         end
      end
   end

   assign indirect_we_out = indirect_we_q;
   assign indirect_wdata_out = indirect_wdata_q;

   // ==========================================================
   // Port registers
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         port5_q <= `CPSR_PORT_RST;
         port6_q <= `CPSR_PORT_RST;
      end else if (bus_wr) begin
         if (bus_idx == `CPSR_IDX_PORT5) begin
            port5_q <= avs_writedata_in[7:0];
         end
         if (bus_idx == `CPSR_IDX_PORT6) begin
            port6_q <= avs_writedata_in[7:0];
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         port7_q <= {`CPSR_P7_TRIM_RST, `CPSR_P7_FREQ_RST, 2'h0};
      end else if (bus_wr && (bus_idx == `CPSR_IDX_PORT7)) begin
         if (SIM_VARIANT) begin
            port7_q <= avs_writedata_in[7:0];
         end else begin
            port7_q[1:0] <= avs_writedata_in[1:0];
         end
      end
   end

   // production hides bits seven to two
   assign port7_view = SIM_VARIANT ? port7_q : (port7_q & `CPSR_P7_IO_MASK);
   assign port_five_out = port5_q;
   assign port_six_out = port6_q;
   assign port_seven_out = port7_view;
   assign osc_freq_sel_hi_out = port7_q[`CPSR_P7_FREQ_LO+1];
   assign osc_freq_sel_lo_out = port7_q[`CPSR_P7_FREQ_LO];
   assign osc_trim_field_out = port7_q[`CPSR_P7_TRIM_LO +: 4];

   // ==========================================================
   // Read path, captured in the wait cycle
   always_comb begin
      case (bus_idx)
         `CPSR_IDX_INDIRECT: rd_mux = indirect_rdata_in;
         `CPSR_IDX_PC_LOW: rd_mux = pc_q[7:0];
         `CPSR_IDX_STATUS: rd_mux = status_q;
         `CPSR_IDX_RAM_SEL: rd_mux = ram_sel_q;
         `CPSR_IDX_PORT5: rd_mux = port5_q;
         `CPSR_IDX_PORT6: rd_mux = port6_q;
         `CPSR_IDX_PORT7: rd_mux = port7_view;
         `CPSR_IDX_CORE_VIEW: rd_mux = {1'b0, sp_q, 1'b0, pc_q[10:8]};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read_in && (bus_q == BUS_IDLE)) begin
         rdata_q <= {24'h000000, rd_mux};
      end
   end

   assign avs_readdata_out = rdata_q;

endmodule

/* src/cpsr_pkg.sv */
// Types shared by the core program counter, stack and status block
package cpsr_pkg;

   // ==========================================================
   // Basic widths
   typedef logic [10:0] cpsr_pc_t;
   typedef logic [2:0] cpsr_sp_t;

   // ==========================================================
   // Program flow operations given by the decoder
   typedef enum logic [3:0] {
      OP_STEP,
      OP_PAGE_JUMP,
      OP_PAGE_CALL,
      OP_LONG_JUMP,
      OP_LONG_SUBROUTINE_CALL,
      OP_SUBROUTINE_RETURN,
      OP_RETURN_WITH_LITERAL,
      OP_INTERRUPT_RETURN,
      OP_ADD_ACC_TO_PC,
      OP_MOVE_ACC_TO_PC,
      OP_WRITE_PC_LOW,
      OP_ENTER_SLEEP_INSTR,
      OP_WATCHDOG_CLEAR_INSTR
   } cpsr_op_t;

   // ==========================================================
   // Bus answer states
   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_DONE
   } cpsr_bus_state_t;

endpackage

/* src/cpsr_stack_mem.sv */
// Eight entry return address memory with registered read data
`timescale 1ns/1ps

module cpsr_stack_mem
   import cpsr_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic we_in,
   input wire cpsr_sp_t waddr_in,
   input wire cpsr_pc_t wdata_in,
   input wire cpsr_sp_t raddr_in,
   output cpsr_pc_t rdata_out
);

   cpsr_pc_t mem_q [0:7];
   cpsr_pc_t rdata_q;

   // Entry storage, no reset needed
   always_ff @(posedge clock_in) begin
      if (we_in) begin
         mem_q[waddr_in] <= wdata_in;
      end
   end

   // Registered read, new write data forwarded
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         rdata_q <= `CPSR_PC_RST;
      end else if (we_in && (waddr_in == raddr_in)) begin
         rdata_q <= wdata_in;
      end else begin
         rdata_q <= mem_q[raddr_in];
      end
   end

   assign rdata_out = rdata_q;

endmodule
